// ---- verilog/charger_cfg_irq_ack_led_blink.sv ----
// Serial-bus register block: regulator irq acknowledge, charger config, two LED drivers
`timescale 1ns/10ps
`default_nettype none
module charger_cfg_irq_ack_led_blink
  import charger_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h48,
  parameter int         TICK_LEN    = TICK_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // Serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // Regulator interrupt path
  input  wire logic [7:0] i_regulator_status,
  input  wire logic [7:0] i_regulator_mask,
  input  wire logic [7:0] i_regulator_ack_req,
  output logic            o_int_out,
  output logic            o_int_oe,
  // Charger analog status
  input  wire logic       i_ac_valid,
  input  wire logic       i_usb_valid,
  input  wire logic       i_vcc_above_undervoltage_lockout,
  input  wire logic       i_taper_comparator,
  input  wire logic       i_taper_timer_done,
  input  wire logic       i_charger_led_on,
  // Charger controls
  output logic            o_force_on_mode,
  output logic            o_wait_mode_enable,
  output logic            o_charger_reset,
  output logic            o_charger_restart,
  output logic            o_timers_enable,
  output logic            o_taper_status,
  output logic [1:0]      o_current_scale,
  output logic [6:0]      o_current_percent,
  output logic [9:0]      o_usb_limit_ma,
  output logic            o_charge_from_ac,
  output logic            o_charge_from_usb,
  // LED open-drain pins
  output logic            o_first_led_out,
  output logic            o_first_led_oe,
  output logic            o_second_led_out,
  output logic            o_second_led_oe
);

  localparam int SYNC_W = 16;
  // Serial lines idle high, so their stages reset high and no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 16'hC000;

  // Two-stage synchronisers for the serial pins and status inputs; mask and ack request are used unsynchronised
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              scl_s;
  logic              sda_s;
  logic              scl_prev_q;
  logic              sda_prev_q;
  logic [7:0]        status_s;
  logic              ac_s;
  logic              usb_s;
  logic              vcc_s;
  logic              taper_cmp_s;
  logic              taper_tmr_s;
  logic              chg_led_s;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {i_scl, i_sda, i_regulator_status, i_ac_valid, i_usb_valid,
                  i_vcc_above_undervoltage_lockout, i_taper_comparator, i_taper_timer_done,
                  i_charger_led_on};
      sync2_q <= sync1_q;
    end
  end

  assign scl_s       = sync2_q[15];
  assign sda_s       = sync2_q[14];
  assign status_s    = sync2_q[13:6];
  assign ac_s        = sync2_q[5];
  assign usb_s       = sync2_q[4];
  assign vcc_s       = sync2_q[3];
  assign taper_cmp_s = sync2_q[2];
  assign taper_tmr_s = sync2_q[1];
  assign chg_led_s   = sync2_q[0];

  // Bus line edges and conditions
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Register storage
  logic [7:0] irq_ack_q;
  logic [7:0] irq_ack_d;
  logic [7:0] cfg_q;
  logic [7:0] first_led_on_time_q;
  logic [7:0] first_led_period_q;
  logic [7:0] second_led_on_time_q;
  logic [7:0] second_led_period_q;

  // Serial slave
  serial_state_e state_q;
  serial_state_e state_d;
  logic [3:0]    bit_cnt_q;
  logic [3:0]    bit_cnt_d;
  logic [7:0]    shift_q;
  logic [7:0]    shift_d;
  logic [7:0]    rd_byte_q;
  logic [7:0]    rd_byte_d;
  logic [7:0]    ptr_q;
  logic [7:0]    ptr_d;
  logic          read_q;
  logic          read_d;
  logic          nack_q;
  logic          nack_d;
  logic          sda_drive_q;
  logic          sda_drive_d;
  logic          wr_stb;
  logic [7:0]    rd_data;
  logic          byte_done;

  assign byte_done = scl_fall & (bit_cnt_q == 4'h8);

  // Read multiplexer; unmapped offsets read as zero
  assign rd_data = (ptr_q == ADDR_REG_IRQ_ACK)    ? irq_ack_q  :
                   (ptr_q == ADDR_CHARGER_CONFIG) ? cfg_q      :
                   (ptr_q == ADDR_FIRST_LED_ON)   ? first_led_on_time_q  :
                   (ptr_q == ADDR_FIRST_LED_PER)  ? first_led_period_q :
                   (ptr_q == ADDR_SECOND_LED_ON)  ? second_led_on_time_q  :
                   (ptr_q == ADDR_SECOND_LED_PER) ? second_led_period_q : READ_UNMAPPED;

  always_comb begin
    state_d     = state_q;
    bit_cnt_d   = bit_cnt_q;
    shift_d     = shift_q;
    rd_byte_d   = rd_byte_q;
    ptr_d       = ptr_q;
    read_d      = read_q;
    nack_d      = nack_q;
    sda_drive_d = sda_drive_q;
    wr_stb      = 1'b0;
    if (bus_start) begin
      state_d     = ST_ADDR;
      bit_cnt_d   = 4'h0;
      sda_drive_d = 1'b0;
    end else if (bus_stop) begin
      state_d     = ST_IDLE;
      sda_drive_d = 1'b0;
    end else begin
      if (scl_rise && (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WR)) begin
        shift_d   = {shift_q[6:0], sda_s};
        bit_cnt_d = bit_cnt_q + 4'h1;
      end
      case (state_q)
        ST_IDLE: begin
          sda_drive_d = 1'b0;
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (shift_q[7:1] == DEVICE_ADDR) begin
              state_d     = ST_ADDR_ACK;
              read_d      = shift_q[0];
              sda_drive_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_d = 4'h0;
            if (read_q) begin
              state_d     = ST_RD;
              rd_byte_d   = rd_data;
              sda_drive_d = ~rd_data[7];
            end else begin
              state_d     = ST_PTR;
              sda_drive_d = 1'b0;
            end
          end
        end
        ST_PTR: begin
          if (byte_done) begin
            state_d     = ST_PTR_ACK;
            ptr_d       = shift_q;
            sda_drive_d = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            state_d     = ST_WR;
            bit_cnt_d   = 4'h0;
            sda_drive_d = 1'b0;
          end
        end
        ST_WR: begin
          if (byte_done) begin
            state_d     = ST_WR_ACK;
            wr_stb      = 1'b1;
            ptr_d       = ptr_q + 8'h01;
            sda_drive_d = 1'b1;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            state_d     = ST_RD_ACK;
            ptr_d       = ptr_q + 8'h01;
            sda_drive_d = 1'b0;
          end else if (scl_fall) begin
            rd_byte_d   = {rd_byte_q[6:0], 1'b0};
            sda_drive_d = ~rd_byte_q[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end
          if (scl_fall) begin
            bit_cnt_d = 4'h0;
            if (nack_q) begin
              state_d = ST_IDLE;
            end else begin
              state_d     = ST_RD;
              rd_byte_d   = rd_data;
              sda_drive_d = ~rd_data[7];
            end
          end
        end
        default: begin
          state_d     = ST_IDLE;
          sda_drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      rd_byte_q   <= 8'h00;
      ptr_q       <= 8'h00;
      read_q      <= 1'b0;
      nack_q      <= 1'b0;
      sda_drive_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      bit_cnt_q   <= bit_cnt_d;
      shift_q     <= shift_d;
      rd_byte_q   <= rd_byte_d;
      ptr_q       <= ptr_d;
      read_q      <= read_d;
      nack_q      <= nack_d;
      sda_drive_q <= sda_drive_d;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_drive_q;

  // Writable registers; the acknowledge register has no write path
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cfg_q      <= RST_CHARGER_CONFIG;
      first_led_on_time_q  <= RST_LED;
      first_led_period_q <= RST_LED;
      second_led_on_time_q  <= RST_LED;
      second_led_period_q <= RST_LED;
    end else if (wr_stb) begin
      if (ptr_q == ADDR_CHARGER_CONFIG) cfg_q <= shift_q;
      if (ptr_q == ADDR_FIRST_LED_ON) first_led_on_time_q <= shift_q;
      if (ptr_q == ADDR_FIRST_LED_PER) first_led_period_q <= shift_q;
      if (ptr_q == ADDR_SECOND_LED_ON) second_led_on_time_q <= shift_q;
      if (ptr_q == ADDR_SECOND_LED_PER) second_led_period_q <= shift_q;
    end
  end

  // Regulator interrupt: pending on unmasked rise, acknowledged per bit
  logic [7:0] status_prev_q;
  logic [7:0] pending_q;
  logic [7:0] pending_d;
  logic [7:0] status_rise;

  assign status_rise = status_s & ~status_prev_q;
  // Ack only takes while the condition stands; it drops with the condition
  assign irq_ack_d   = (irq_ack_q | (i_regulator_ack_req & ~pending_q & status_s) |
                        (i_regulator_ack_req & pending_q)) & status_s;
  // A new rise wins over an acknowledge in the same cycle
  assign pending_d   = (pending_q & ~i_regulator_ack_req & status_s) |
                       (status_rise & ~i_regulator_mask);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      status_prev_q <= 8'h00;
      pending_q     <= 8'h00;
      irq_ack_q     <= RST_IRQ_ACK;
      o_int_oe      <= 1'b0;
    end else begin
      status_prev_q <= status_s;
      pending_q     <= pending_d;
      irq_ack_q     <= irq_ack_d & ~status_rise;
      o_int_oe      <= |pending_d;
    end
  end

  assign o_int_out = 1'b0;

  // Charger control outputs
  logic       source_ok;
  logic       force_on_d;
  logic       usb_charge_ok;
  logic       restart_d;
  logic [6:0] pct_d;

  assign source_ok     = (ac_s | usb_s) & vcc_s;
  assign force_on_d    = ~cfg_q[CFG_AUTO_START_INHIBIT] & source_ok;
  assign usb_charge_ok = cfg_q[CFG_USB_ALLOWED];
  assign restart_d     = cfg_q[CFG_CHARGER_RESET] & ~o_charger_reset;
  assign pct_d = (cfg_q[CFG_CURRENT_MSB:CFG_CURRENT_LSB] == 2'h3) ? CURRENT_PCT_100 :
                 (cfg_q[CFG_CURRENT_MSB:CFG_CURRENT_LSB] == 2'h2) ? CURRENT_PCT_75  :
                 (cfg_q[CFG_CURRENT_MSB:CFG_CURRENT_LSB] == 2'h1) ? CURRENT_PCT_50  :
                                                                    CURRENT_PCT_25;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_force_on_mode    <= 1'b0;
      o_wait_mode_enable <= 1'b1;
      o_charger_reset    <= 1'b0;
      o_charger_restart  <= 1'b0;
      o_timers_enable    <= 1'b0;
      o_taper_status     <= 1'b0;
      o_current_scale    <= 2'h3;
      o_current_percent  <= CURRENT_PCT_100;
      o_usb_limit_ma     <= USB_LIMIT_LOW_MA;
      o_charge_from_ac   <= 1'b0;
      o_charge_from_usb  <= 1'b0;
    end else begin
      o_force_on_mode    <= force_on_d;
      o_wait_mode_enable <= ~force_on_d;
      o_charger_reset    <= cfg_q[CFG_CHARGER_RESET];
      o_charger_restart  <= restart_d;
      o_timers_enable    <= cfg_q[CFG_TIMER_ENABLE];
      o_taper_status     <= cfg_q[CFG_TIMER_ENABLE] ? taper_tmr_s : taper_cmp_s;
      o_current_scale    <= cfg_q[CFG_CURRENT_MSB:CFG_CURRENT_LSB];
      o_current_percent  <= pct_d;
      o_usb_limit_ma     <= (usb_charge_ok & cfg_q[CFG_USB_500MA]) ?
                            USB_LIMIT_HIGH_MA : USB_LIMIT_LOW_MA;
      o_charge_from_ac   <= cfg_q[CFG_CHARGE_ENABLE] & ac_s;
      o_charge_from_usb  <= cfg_q[CFG_CHARGE_ENABLE] & usb_charge_ok & usb_s &
                            ~ac_s;
    end
  end

  // 10 ms step tick shared by both LEDs
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic                  tick;

  assign tick = (tick_cnt_q == TICK_CNT_W'(TICK_LEN - 1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 20'h00001;
    end
  end

  logic first_led_on;
  logic second_led_on;

  led_blinker #(
    .HAS_CHARGER_MODE (1'b1)
  ) u_first_led (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_tick       (tick),
    .i_mode       ({first_led_on_time_q[LED_SEL_BIT], first_led_period_q[LED_SEL_BIT]}),
    .i_on_time    (first_led_on_time_q[LED_FIELD_MSB:0]),
    .i_period     (first_led_period_q[LED_FIELD_MSB:0]),
    .i_charger_on (chg_led_s),
    .o_led_on     (first_led_on)
  );

  led_blinker #(
    .HAS_CHARGER_MODE (1'b0)
  ) u_second_led (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_tick       (tick),
    .i_mode       ({second_led_on_time_q[LED_SEL_BIT], second_led_period_q[LED_SEL_BIT]}),
    .i_on_time    (second_led_on_time_q[LED_FIELD_MSB:0]),
    .i_period     (second_led_period_q[LED_FIELD_MSB:0]),
    .i_charger_on (1'b0),
    .o_led_on     (second_led_on)
  );

  assign o_first_led_out  = 1'b0;
  assign o_first_led_oe   = first_led_on;
  assign o_second_led_out = 1'b0;
  assign o_second_led_oe  = second_led_on;

endmodule : charger_cfg_irq_ack_led_blink
`default_nettype wire

// ---- verilog/charger_pkg.sv ----
// Shared constants and types for the charger configuration and LED register block
package charger_pkg;

  // Register offsets on the serial bus
  localparam logic [7:0] ADDR_REG_IRQ_ACK    = 8'h06;
  localparam logic [7:0] ADDR_CHARGER_CONFIG = 8'h07;
  localparam logic [7:0] ADDR_FIRST_LED_ON   = 8'h08;
  localparam logic [7:0] ADDR_FIRST_LED_PER  = 8'h09;
  localparam logic [7:0] ADDR_SECOND_LED_ON  = 8'h0A;
  localparam logic [7:0] ADDR_SECOND_LED_PER = 8'h0B;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // Reset values
  localparam logic [7:0] RST_IRQ_ACK        = 8'h00;
  localparam logic [7:0] RST_CHARGER_CONFIG = 8'h1B;
  localparam logic [7:0] RST_LED            = 8'h00;

  // Charger configuration field positions
  localparam int CFG_AUTO_START_INHIBIT = 7;
  localparam int CFG_CHARGER_RESET      = 6;
  localparam int CFG_TIMER_ENABLE       = 5;
  localparam int CFG_CURRENT_MSB        = 4;
  localparam int CFG_CURRENT_LSB        = 3;
  localparam int CFG_USB_500MA          = 2;
  localparam int CFG_USB_ALLOWED        = 1;
  localparam int CFG_CHARGE_ENABLE      = 0;

  // LED register fields
  localparam int LED_SEL_BIT   = 7;
  localparam int LED_FIELD_MSB = 6;

  // LED modes (upper select bit, lower select bit)
  localparam logic [1:0] LED_MODE_CHARGER = 2'h0;
  localparam logic [1:0] LED_MODE_BLINK   = 2'h1;
  localparam logic [1:0] LED_MODE_OFF     = 2'h2;
  localparam logic [1:0] LED_MODE_ON      = 2'h3;

  // Constant current phase scaling, percent of the resistor-set maximum
  localparam logic [6:0] CURRENT_PCT_25  = 7'h19;
  localparam logic [6:0] CURRENT_PCT_50  = 7'h32;
  localparam logic [6:0] CURRENT_PCT_75  = 7'h4B;
  localparam logic [6:0] CURRENT_PCT_100 = 7'h64;

  // USB charge current limits in mA
  localparam logic [9:0] USB_LIMIT_LOW_MA  = 10'h064;
  localparam logic [9:0] USB_LIMIT_HIGH_MA = 10'h1F4;

  // Timing
  localparam int CLK_FREQ_HZ     = 40_000_000;
  localparam int ON_STEP_MS      = 10;
  localparam int PER_STEP_MS     = 100;
  localparam int TICK_CYCLES     = CLK_FREQ_HZ / 1000 * ON_STEP_MS;
  localparam int PER_STEP_TICKS  = PER_STEP_MS / ON_STEP_MS;
  localparam int BLINK_CNT_W     = 11;
  localparam int TICK_CNT_W      = 20;

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR      = 4'h3,
    ST_PTR_ACK  = 4'h4,
    ST_WR       = 4'h5,
    ST_WR_ACK   = 4'h6,
    ST_RD       = 4'h7,
    ST_RD_ACK   = 4'h8
  } serial_state_e;

endpackage : charger_pkg

// ---- verilog/led_blinker.sv ----
// One LED output: mode select plus on-time / period blink timing
`timescale 1ns/10ps
`default_nettype none
module led_blinker
  import charger_pkg::*;
#(
  parameter bit HAS_CHARGER_MODE = 1'b1
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_tick,
  input  wire logic [1:0] i_mode,
  input  wire logic [6:0] i_on_time,
  input  wire logic [6:0] i_period,
  input  wire logic       i_charger_on,
  output logic            o_led_on
);

  logic [BLINK_CNT_W-1:0] cnt_q;
  logic [BLINK_CNT_W-1:0] cnt_d;
  logic [BLINK_CNT_W-1:0] on_ticks;
  logic [BLINK_CNT_W-1:0] per_ticks;
  logic                   led_d;
  logic                   blinking;
  logic                   period_end;

  // Field value 0 is one step; each step is one tick or ten ticks
  assign on_ticks   = {4'h0, i_on_time} + 11'h001;
  assign per_ticks  = BLINK_CNT_W'(({4'h0, i_period} + 11'h001) * PER_STEP_TICKS);
  assign blinking   = (i_mode == LED_MODE_BLINK);
  assign period_end = (cnt_q >= per_ticks - 11'h001);

  always_comb begin
    cnt_d = cnt_q;
    if (!blinking) begin
      cnt_d = '0;
    end else if (i_tick) begin
      cnt_d = period_end ? '0 : cnt_q + 11'h001;
    end
  end

  always_comb begin
    case (i_mode)
      LED_MODE_CHARGER: led_d = HAS_CHARGER_MODE ? i_charger_on : 1'b0;
      LED_MODE_BLINK:   led_d = (cnt_q < on_ticks);
      LED_MODE_OFF:     led_d = 1'b0;
      LED_MODE_ON:      led_d = 1'b1;
      default:          led_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_q    <= '0;
      o_led_on <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      o_led_on <= led_d;
    end
  end

endmodule : led_blinker
`default_nettype wire

// ---- test/charger_cfg_irq_ack_led_blink_properties.sv ----
// Port-level property checks for the charger register block
`timescale 1ns/10ps
`default_nettype none
module charger_cfg_irq_ack_led_blink_properties (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_regulator_status,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic       o_int_out,
  input wire logic       o_int_oe,
  input wire logic       o_force_on_mode,
  input wire logic       o_wait_mode_enable,
  input wire logic       o_charger_reset,
  input wire logic       o_charger_restart,
  input wire logic [1:0] o_current_scale,
  input wire logic [6:0] o_current_percent,
  input wire logic [9:0] o_usb_limit_ma,
  input wire logic       o_charge_from_ac,
  input wire logic       o_charge_from_usb,
  input wire logic       o_first_led_out,
  input wire logic       o_second_led_out
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence restart_pulse;
    o_charger_restart ##1 !o_charger_restart;
  endsequence
  a_force_wait_pair: assert property (o_wait_mode_enable == !o_force_on_mode)
    else $error("wait enable not inverse of force on");
  a_restart_on_set: assert property ($rose(o_charger_reset) |-> restart_pulse)
    else $error("no single restart pulse");
  a_scale_percent: assert property (
    o_current_percent == 7'(7'h19 * ({5'h00, o_current_scale} + 7'h01)))
    else $error("current percent does not match scale");
  a_single_source: assert property (!(o_charge_from_ac && o_charge_from_usb))
    else $error("both sources charging");
  a_usb_limit_vals: assert property (o_usb_limit_ma inside {10'h064, 10'h1F4})
    else $error("usb limit not 100 or 500");
  a_int_has_cause: assert property ($rose(o_int_oe) |->
    ($past(i_regulator_status, 2) | $past(i_regulator_status, 3)) != 8'h00)
    else $error("interrupt without status");
  a_open_drain_low: assert property (
    !o_sda_out && !o_int_out && !o_first_led_out && !o_second_led_out)
    else $error("open-drain data level not low");
  a_reset_defaults: assert property ($past(i_reset) |-> o_current_scale == 2'h3
    && !o_sda_oe && !o_int_oe && o_usb_limit_ma == 10'h064)
    else $error("outputs not at defaults after reset");
endmodule : charger_cfg_irq_ack_led_blink_properties
bind charger_cfg_irq_ack_led_blink charger_cfg_irq_ack_led_blink_properties chk_u (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_regulator_status(i_regulator_status),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
  .o_force_on_mode(o_force_on_mode), .o_wait_mode_enable(o_wait_mode_enable),
  .o_charger_reset(o_charger_reset), .o_charger_restart(o_charger_restart),
  .o_current_scale(o_current_scale), .o_current_percent(o_current_percent),
  .o_usb_limit_ma(o_usb_limit_ma), .o_charge_from_ac(o_charge_from_ac),
  .o_charge_from_usb(o_charge_from_usb), .o_first_led_out(o_first_led_out),
  .o_second_led_out(o_second_led_out));
`default_nettype wire

// ---- test/serial_host_model.sv ----
// Host on the two-wire serial bus: drives SCL, shares the pulled-up SDA line
`timescale 1ns/10ps
`default_nettype none
module serial_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic pull_low = 1'b0;
  initial o_scl = 1'b1;
  // Released line floats up through the pull-up
  assign o_sda = ~(pull_low | i_sda_oe);
  task automatic step(input logic c, input logic l, input int n);
    o_scl = c;
    pull_low = l;
    repeat (n) @(negedge i_sys_clk);
  endtask : step
  task automatic bit_x(input logic b, output logic s);
    step(1'b0, ~b, 2);
    step(1'b1, ~b, 2);
    s = o_sda;
    step(1'b1, ~b, 2);
    step(1'b0, ~b, 2);
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r,
                        output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
      r[i] = s;
    end
    bit_x(m, s);
    ak = ~s;
  endtask : byte_x
  task automatic start;
    step(1'b0, 1'b0, 2);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
  endtask : start
  task automatic stop;
    step(1'b0, 1'b1, 2);
    step(1'b1, 1'b1, 4);
    step(1'b1, 1'b0, 4);
  endtask : stop
  task automatic write_reg(input logic [7:0] a, d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start;
    byte_x({ADDR, 1'b0}, 1'b1, r, k0);
    byte_x(a, 1'b1, r, k1);
    byte_x(d, 1'b1, r, k2);
    stop;
    ok = k0 & k1 & k2;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, kn;
    start;
    byte_x({ADDR, 1'b0}, 1'b1, d, k0);
    byte_x(a, 1'b1, d, k1);
    start;
    byte_x({ADDR, 1'b1}, 1'b1, d, k2);
    byte_x(8'hFF, 1'b1, d, kn);
    stop;
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : serial_host_model
`default_nettype wire

// ---- test/charger_cfg_irq_ack_led_blink_test.sv ----
// Bench for the charger config, irq acknowledge and LED block
`timescale 1ns/10ps
`default_nettype none
module charger_cfg_irq_ack_led_blink_test;
  logic       clk = 1'b0, rst = 1'b1, ac = 1'b0, usb = 1'b0, vcc = 1'b0, tpc = 1'b0;
  logic       tpt = 1'b0, cled = 1'b0, scl, sda, so, soe, io, ioe, fon, wte, crst, crs;
  logic       ten, tps, fac, fus, l1o, l1e, l2o, l2e;
  logic [7:0] st = 8'h00, mk = 8'h00, ackr = 8'h00;
  logic [1:0] csc;
  logic [6:0] pct;
  logic [9:0] lim;
  int         err_total = 0, comparisons = 0, restarts = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (crs === 1'b1) restarts <= restarts + 1;
  charger_cfg_irq_ack_led_blink #(.TICK_LEN(40)) dut_u (
    .i_sys_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(so), .o_sda_oe(soe),
    .i_regulator_status(st), .i_regulator_mask(mk), .i_regulator_ack_req(ackr),
    .o_int_out(io), .o_int_oe(ioe), .i_ac_valid(ac), .i_usb_valid(usb), .i_vcc_above_undervoltage_lockout(vcc),
    .i_taper_comparator(tpc), .i_taper_timer_done(tpt), .i_charger_led_on(cled),
    .o_force_on_mode(fon), .o_wait_mode_enable(wte), .o_charger_reset(crst),
    .o_charger_restart(crs), .o_timers_enable(ten), .o_taper_status(tps),
    .o_current_scale(csc), .o_current_percent(pct), .o_usb_limit_ma(lim),
    .o_charge_from_ac(fac), .o_charge_from_usb(fus), .o_first_led_out(l1o),
    .o_first_led_oe(l1e), .o_second_led_out(l2o), .o_second_led_oe(l2e));
  serial_host_model host_u (.i_sys_clk(clk), .i_sda_oe(soe), .o_scl(scl), .o_sda(sda));
  task automatic chv(input string n, input logic [9:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chv
  task automatic chb(input string n, input logic e, g);
    chv(n, {9'h000, e}, {9'h000, g});
  endtask : chb
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, d);
    logic k;
    host_u.write_reg(a, d, k);
    chb("write ack", 1'b1, k);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    logic k;
    host_u.read_reg(a, d, k);
    chb("read ack", 1'b1, k);
    chv("read data", {2'h0, e}, {2'h0, d});
  endtask : rd
  // Count LED-on cycles over n clocks once the pattern has settled
  task automatic on_count(input logic w, input int n, e, input string s);
    int c = 0;
    repeat (n) @(negedge clk);
    repeat (n) @(negedge clk) c += int'(w ? l2e : l1e);
    chv(s, 10'(e), 10'(c));
  endtask : on_count
  task automatic t_reset;
    logic [7:0] dflt [6] = '{8'h00, 8'h1B, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) rd(8'h06 + 8'(i), dflt[i]);
    rd(8'h20, 8'h00);
  endtask : t_reset
  task automatic t_cfg;
    for (int c = 0; c < 4; c++) begin
      wr(8'h07, {3'h0, 2'(c), 3'h3});
      chv("percent", 10'(25 * (c + 1)), {3'h0, pct});
      chv("scale", 10'(c), {8'h00, csc});
    end
    usb = 1'b1;
    wr(8'h07, 8'h07);
    chv("usb limit", 10'h1F4, lim);
    chb("from usb", 1'b1, fus);
    wr(8'h07, 8'h05);
    chv("usb limit", 10'h064, lim);
    chb("from usb", 1'b0, fus);
    ac = 1'b1;
    wr(8'h07, 8'h03);
    chb("from ac", 1'b1, fac);
    chb("from usb", 1'b0, fus);
    wr(8'h07, 8'h02);
    chb("from ac", 1'b0, fac);
  endtask : t_cfg
  task automatic t_mode;
    vcc = 1'b1;
    tpc = 1'b1;
    wr(8'h07, 8'h03);
    chb("force on", 1'b1, fon);
    chb("taper", 1'b1, tps);
    wr(8'h07, 8'hA3);
    chb("wait en", 1'b1, wte);
    chb("taper", 1'b0, tps);
    chb("timers", 1'b1, ten);
    wr(8'h07, 8'h43);
    chv("restarts", 10'h001, 10'(restarts));
    wr(8'h07, 8'h03);
    chb("chg reset", 1'b0, crst);
  endtask : t_mode
  task automatic pulse(input logic [7:0] b);
    ackr = b;
    @(negedge clk);
    ackr = 8'h00;
    repeat (3) @(negedge clk);
  endtask : pulse
  task automatic t_irq;
    st = 8'h03;
    repeat (8) @(negedge clk);
    chb("int", 1'b1, ioe);
    pulse(8'h01);
    chb("int", 1'b1, ioe);
    rd(8'h06, 8'h01);
    pulse(8'h02);
    chb("int", 1'b0, ioe);
    st = 8'h02;
    rd(8'h06, 8'h02);
    mk = 8'h04;
    st = 8'h06;
    repeat (8) @(negedge clk);
    chb("int", 1'b0, ioe);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h02);
  endtask : t_irq
  task automatic t_led;
    cled = 1'b1;
    repeat (4) @(negedge clk);
    chb("led1", 1'b1, l1e);
    chb("led2", 1'b0, l2e);
    wr(8'h08, 8'h82);
    chb("led1", 1'b0, l1e);
    wr(8'h09, 8'h80);
    chb("led1", 1'b1, l1e);
    wr(8'h08, 8'h02);
    on_count(1'b0, 800, 240, "led1 blink");
    wr(8'h08, 8'h7F);
    on_count(1'b0, 800, 800, "led1 clamp");
    wr(8'h0A, 8'h80);
    chb("led2", 1'b0, l2e);
    wr(8'h0B, 8'h81);
    chb("led2", 1'b1, l2e);
    wr(8'h0A, 8'h01);
    on_count(1'b1, 800, 80, "led2 blink");
  endtask : t_led
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_reset;
    t_cfg;
    t_mode;
    t_irq;
    t_led;
    report_and_stop;
  end
endmodule : charger_cfg_irq_ack_led_blink_test
`default_nettype wire
